// ==== hw/rnco_consts.svh ====
`ifndef RNCO_CONSTS_SVH
`define RNCO_CONSTS_SVH

// register addresses on the plain register port
`define RNCO_ADDR_SRC      12'h20c
`define RNCO_ADDR_SEL      12'h20d
`define RNCO_ADDR_RDIV     12'h20e
`define RNCO_ADDR_FREQ0    12'h210
`define RNCO_ADDR_FREQ7    12'h217
`define RNCO_ADDR_PHASE    12'h218
`define RNCO_ADDR_ACTIVE   12'h219

// field positions
`define RNCO_SRC_BIT       0
`define RNCO_SEL_MSB       2
`define RNCO_RDIV_MSB      15
`define RNCO_ACT_NONDET    3

// reset values
`define RNCO_RST_SRC       1'b0
`define RNCO_RST_SEL       3'h0
`define RNCO_RST_RDIV      16'h0000
`define RNCO_RST_FREQ      32'hc0000000
`define RNCO_RST_ACC       48'h000000000000

// rational modulus is the divisor scaled by two to the 25th
`define RNCO_RDIV_SHIFT    25
`define RNCO_NUM_PRESETS   8

`endif

// ==== hw/rnco_pkg.sv ====
package rnco_pkg;
  typedef logic [11:0] rnco_addr_t;
  typedef logic [31:0] rnco_word_t;
  typedef logic [15:0] rnco_rdiv_t;
  typedef logic [2:0]  rnco_preset_t;
  typedef logic [47:0] rnco_acc_t;
endpackage : rnco_pkg

// ==== hw/rnco_phase_acc.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rnco_consts.svh"

module rnco_phase_acc (
  input  wire logic                clock_i,
  input  wire logic                rst_n_i,
  input  wire logic                ce_i,
  input  wire logic                sample_en_i,
  input  wire rnco_pkg::rnco_word_t step_i,
  input  wire rnco_pkg::rnco_rdiv_t rdiv_i,
  output var  rnco_pkg::rnco_acc_t  acc_o
);
  import rnco_pkg::*;

  rnco_acc_t acc;
  rnco_acc_t next_acc;
  rnco_acc_t modulus;
  rnco_acc_t sum;

  // rational wrap of a phase value, modulus never zero here
  function automatic rnco_acc_t rat_wrap(input rnco_acc_t x, input rnco_acc_t m);
    return x % m;
  endfunction : rat_wrap

  // step once per sample, wrap on 2^32 or on the rational modulus
  always_comb begin
    modulus  = rnco_acc_t'(rdiv_i) << `RNCO_RDIV_SHIFT;
    sum      = acc + rnco_acc_t'(step_i);
    next_acc = acc;
    if (sample_en_i) begin
      if (rdiv_i == `RNCO_RST_RDIV) begin
        next_acc = {16'h0000, sum[31:0]}; // see R10, see R14
      end else if (acc >= modulus) begin
        next_acc = rat_wrap(rnco_acc_t'(step_i), modulus); // divisor changed under a running phase
      end else if (sum >= modulus) begin
        next_acc = rat_wrap(sum, modulus); // see R12, see R14
      end else begin
        next_acc = sum;
      end
    end
  end

  // registers
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      acc <= `RNCO_RST_ACC;
    end else if (ce_i) begin
      acc <= next_acc;
    end
  end

  assign acc_o = acc;

  a_int_step : assert property (@(posedge clock_i) disable iff (!rst_n_i) // see R10, see R14
    ce_i && sample_en_i && rdiv_i == 16'h0000
    |=> acc[31:0] == 32'($past(acc[31:0]) + $past(step_i)) && acc[47:32] == 16'h0000)
    else $error("integer accumulator step wrong");
  a_rat_bound : assert property (@(posedge clock_i) disable iff (!rst_n_i) // see R14
    ce_i && sample_en_i && rdiv_i != 16'h0000 && $stable(rdiv_i)
    |=> acc < (rnco_acc_t'(rdiv_i) << 25))
    else $error("rational accumulator left its modulus");
  a_freeze : assert property (@(posedge clock_i) disable iff (!rst_n_i) // see R14
    !ce_i |=> $stable(acc))
    else $error("accumulator moved while clock enable low");
  c_rat_wrap : cover property (@(posedge clock_i) disable iff (!rst_n_i)
    ce_i && sample_en_i && rdiv_i != 16'h0000 ##1 acc < $past(acc));
endmodule : rnco_phase_acc

`default_nettype wire

// ==== hw/rnco_top.sv ====
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "rnco_consts.svh"

// Notes on behaviour
// R1 - sixteen-bit read/write rational divisor, resets to zero, refines the step
// R2 - software sets divisor to sample rate over step over 128
// R3 - software avoids combinations giving a fractional divisor
// R4 - software should keep the divisor at or below 8192
// R5 - one divisor serves all eight presets
// R6 - each preset has a 32-bit read/write frequency word, reset c0000000
// R7 - output frequency is active word times 2^-32 times sample rate
// R8 - rewriting a word while the link runs makes phase non-deterministic
// R9 - host reinitialises the link when deterministic phase is needed
// R10 - word handled modulo 2^32, signed and unsigned alike
// R11 - software picks another step and sets divisor when word inexact
// R12 - rational word is rounded 2^25 times frequency over step over divisor
// R13 - active preset from pins when source bit 0, register when 1
// R14 - accumulator advances once per sample, rational modulus when divisor nonzero
module rnco_top (
  input  wire logic                  clock_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  ce_i,
  input  wire logic                  sample_en_i,
  input  wire rnco_pkg::rnco_preset_t preset_pins_i,
  input  wire logic                  link_running_i,
  input  wire logic                  link_reinit_i,
  input  wire rnco_pkg::rnco_addr_t   addr_i,
  input  wire rnco_pkg::rnco_word_t   wr_data_i,
  input  wire logic                  wr_en_i,
  input  wire logic                  rd_en_i,
  output var  rnco_pkg::rnco_word_t   rd_data_o,
  output var  rnco_pkg::rnco_preset_t active_preset_o,
  output var  rnco_pkg::rnco_word_t   active_word_o,
  output var  rnco_pkg::rnco_rdiv_t   rdiv_o,
  output var  rnco_pkg::rnco_word_t   phase_o,
  output var  logic                  phase_nondet_o
);
  import rnco_pkg::*;

  // true for the eight frequency word addresses
  function automatic logic is_freq_addr(input rnco_addr_t a);
    return (a >= `RNCO_ADDR_FREQ0) && (a <= `RNCO_ADDR_FREQ7);
  endfunction : is_freq_addr

  // preset index of a frequency word address
  function automatic rnco_preset_t freq_index(input rnco_addr_t a);
    rnco_addr_t d;
    d = a - `RNCO_ADDR_FREQ0;
    return d[2:0];
  endfunction : freq_index

  // configuration registers
  logic         src_reg;
  logic         next_src_reg;
  rnco_preset_t sel_idx;
  rnco_preset_t next_sel_idx;
  rnco_rdiv_t   rdiv;
  rnco_rdiv_t   next_rdiv;
  rnco_word_t   freq [`RNCO_NUM_PRESETS];
  rnco_word_t   next_freq [`RNCO_NUM_PRESETS];

  // datapath and status
  rnco_preset_t active;
  rnco_preset_t next_active;
  rnco_word_t   act_word;
  rnco_word_t   next_act_word;
  logic         nondet;
  logic         next_nondet;
  rnco_word_t   rd_data;
  rnco_word_t   next_rd_data;
  rnco_acc_t    acc;
  logic         freq_wr;

  assign freq_wr = wr_en_i && is_freq_addr(addr_i);

  // register writes
  always_comb begin
    next_src_reg = src_reg;
    next_sel_idx = sel_idx;
    next_rdiv    = rdiv;
    for (int i = 0; i < `RNCO_NUM_PRESETS; i++) begin
      next_freq[i] = freq[i];
    end
    if (wr_en_i) begin
      if (addr_i == `RNCO_ADDR_SRC) begin
        next_src_reg = wr_data_i[`RNCO_SRC_BIT];
      end
      if (addr_i == `RNCO_ADDR_SEL) begin
        next_sel_idx = wr_data_i[`RNCO_SEL_MSB:0];
      end
      if (addr_i == `RNCO_ADDR_RDIV) begin
        next_rdiv = wr_data_i[`RNCO_RDIV_MSB:0]; // see R1
      end
    end
    if (freq_wr) begin
      next_freq[freq_index(addr_i)] = wr_data_i; // see R6
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      src_reg <= `RNCO_RST_SRC;
      sel_idx <= `RNCO_RST_SEL;
      rdiv    <= `RNCO_RST_RDIV; // see R1
      for (int i = 0; i < `RNCO_NUM_PRESETS; i++) begin
        freq[i] <= `RNCO_RST_FREQ; // see R6
      end
    end else if (ce_i) begin
      src_reg <= next_src_reg;
      sel_idx <= next_sel_idx;
      rdiv    <= next_rdiv;
      for (int i = 0; i < `RNCO_NUM_PRESETS; i++) begin
        freq[i] <= next_freq[i];
      end
    end
  end

  // preset selection, active word and phase status
  always_comb begin
    next_active   = src_reg ? sel_idx : preset_pins_i; // see R13
    next_act_word = freq[active]; // see R7
    next_nondet   = nondet;
    if (link_reinit_i) begin
      next_nondet = 1'b0; // see R9
    end
    if (freq_wr && link_running_i) begin
      next_nondet = 1'b1; // see R8
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      active   <= `RNCO_RST_SEL;
      act_word <= `RNCO_RST_FREQ;
      nondet   <= 1'b0;
    end else if (ce_i) begin
      active   <= next_active;
      act_word <= next_act_word;
      nondet   <= next_nondet;
    end
  end

  // read port, data valid only in the cycle after the strobe
  always_comb begin
    next_rd_data = 32'h00000000;
    if (rd_en_i) begin
      if (addr_i == `RNCO_ADDR_SRC) begin
        next_rd_data = {31'h00000000, src_reg};
      end else if (addr_i == `RNCO_ADDR_SEL) begin
        next_rd_data = {29'h00000000, sel_idx};
      end else if (addr_i == `RNCO_ADDR_RDIV) begin
        next_rd_data = {16'h0000, rdiv}; // see R1
      end else if (is_freq_addr(addr_i)) begin
        next_rd_data = freq[freq_index(addr_i)]; // see R6
      end else if (addr_i == `RNCO_ADDR_PHASE) begin
        next_rd_data = acc[31:0];
      end else if (addr_i == `RNCO_ADDR_ACTIVE) begin
        next_rd_data = {28'h0000000, nondet, active};
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rd_data <= 32'h00000000;
    end else if (ce_i) begin
      rd_data <= next_rd_data;
    end
  end

  // phase accumulator, one divisor for every preset
  rnco_phase_acc u_acc (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n_i),
    .ce_i        (ce_i),
    .sample_en_i (sample_en_i),
    .step_i      (act_word),
    .rdiv_i      (rdiv), // see R5
    .acc_o       (acc)
  );

  // outputs straight from flops
  assign rd_data_o       = rd_data;
  assign active_preset_o = active;
  assign active_word_o   = act_word;
  assign rdiv_o          = rdiv;
  assign phase_o         = acc[31:0];
  assign phase_nondet_o  = nondet;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  a_reset_values : assert property (disable iff (1'b0) // see R1, see R6
    !rst_n_i |=> rdiv == 16'h0000 && freq[0] == 32'hc0000000 && freq[7] == 32'hc0000000)
    else $error("reset values wrong");
  a_rdiv_write : assert property ( // see R1
    ce_i && wr_en_i && addr_i == 12'h20e |=> rdiv == $past(wr_data_i[15:0]))
    else $error("divisor write not stored");
  a_rdiv_read : assert property ( // see R1
    ce_i && rd_en_i && addr_i == 12'h20e |=> rd_data_o == {16'h0000, $past(rdiv)})
    else $error("divisor read wrong");
  a_freq_write : assert property ( // see R6
    ce_i && freq_wr |=> freq[$past(freq_index(addr_i))] == $past(wr_data_i))
    else $error("frequency word write not stored");
  a_read_once : assert property ( // see R1
    ce_i && !rd_en_i |=> rd_data_o == 32'h00000000)
    else $error("read data stands outside its cycle");
  a_preset_pins : assert property ( // see R13
    ce_i && !src_reg |=> active_preset_o == $past(preset_pins_i))
    else $error("pin preset not followed");
  a_preset_reg : assert property ( // see R13
    ce_i && src_reg |=> active_preset_o == $past(sel_idx))
    else $error("register preset not followed");
  a_word_follow : assert property ( // see R7
    ce_i |=> active_word_o == $past(freq[active]))
    else $error("active word lags the preset");
  a_nondet_set : assert property ( // see R8
    ce_i && freq_wr && link_running_i |=> phase_nondet_o)
    else $error("running-link rewrite not flagged");
  a_nondet_clear : assert property ( // see R9
    ce_i && link_reinit_i && !(freq_wr && link_running_i) |=> !phase_nondet_o)
    else $error("reinit did not clear flag");

  c_rewrite_running : cover property (ce_i && freq_wr && link_running_i);
  c_src_switch : cover property (ce_i && !src_reg ##1 ce_i && src_reg);
  c_rational_run : cover property (ce_i && sample_en_i && rdiv != 16'h0000);
endmodule : rnco_top

`default_nettype wire

// ==== tb/rnco_top_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rnco_consts.svh"

module rnco_top_bench;
  import rnco_pkg::*;
  logic         clock_i, rst_n_i, ce_i, sample_en_i, link_running_i, link_reinit_i;
  logic         wr_en_i, rd_en_i, phase_nondet_o, pend;
  rnco_preset_t preset_pins_i, active_preset_o;
  rnco_addr_t   addr_i;
  rnco_word_t   wr_data_i, rd_data_o, active_word_o, phase_o;
  rnco_rdiv_t   rdiv_o, rdiv;
  rnco_word_t   freq [8];
  rnco_word_t   exp_q [$];
  logic [63:0]  acc, modulus;
  int           mismatches, tests_run, n;

  rnco_top dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .sample_en_i(sample_en_i),
    .preset_pins_i(preset_pins_i), .link_running_i(link_running_i),
    .link_reinit_i(link_reinit_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
    .active_preset_o(active_preset_o), .active_word_o(active_word_o), .rdiv_o(rdiv_o),
    .phase_o(phase_o), .phase_nondet_o(phase_nondet_o));

  // 10 mhz clock
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic wr(input rnco_addr_t a, input rnco_word_t d);
    @(posedge clock_i);
    addr_i    <= a;
    wr_data_i <= d;
    wr_en_i   <= 1'b1;
    @(posedge clock_i);
    wr_en_i   <= 1'b0;
  endtask : wr

  // read strobe; expected data goes to the watcher queue
  task automatic rd(input rnco_addr_t a, input rnco_word_t e);
    @(posedge clock_i);
    addr_i  <= a;
    rd_en_i <= 1'b1;
    exp_q.push_back(e);
    @(posedge clock_i);
    rd_en_i <= 1'b0;
  endtask : rd

  task automatic wait_n(input int k);
    repeat (k) @(posedge clock_i);
    @(negedge clock_i);
  endtask : wait_n

  task automatic steps(input int k);
    @(posedge clock_i);
    sample_en_i <= 1'b1;
    repeat (k) @(posedge clock_i);
    sample_en_i <= 1'b0;
  endtask : steps

  // read data watcher, one cycle after each taken read
  always @(negedge clock_i) begin
    if (pend) begin
      if (exp_q.size() == 0) check("read_queue", 32'h1, 32'h0);
      else check("rd_data", rd_data_o, exp_q.pop_front());
    end
    pend = rd_en_i & ce_i & rst_n_i;
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge clock_i);
    mismatches++;
    stop_test();
  end

  // main sequence
  initial begin
    {rst_n_i, sample_en_i, link_running_i, link_reinit_i, wr_en_i, rd_en_i, pend} = '0;
    ce_i = 1'b1;
    preset_pins_i = '0;
    addr_i = '0;
    wr_data_i = '0;
    mismatches = 0;
    tests_run = 0;
    void'($urandom(46));
    repeat (20) @(posedge clock_i);
    rst_n_i <= 1'b1;
    // reset values
    rd(`RNCO_ADDR_RDIV, 32'h0);
    rd(`RNCO_ADDR_SRC, 32'h0);
    rd(`RNCO_ADDR_SEL, 32'h0);
    for (int i = 0; i < 8; i++) rd(rnco_addr_t'(`RNCO_ADDR_FREQ0 + i), `RNCO_RST_FREQ);
    @(negedge clock_i);
    check("active_word", active_word_o, `RNCO_RST_FREQ);
    // random words and divisor, read back
    for (int i = 0; i < 8; i++) begin
      freq[i] = $urandom;
      wr(rnco_addr_t'(`RNCO_ADDR_FREQ0 + i), freq[i]);
    end
    rdiv = 16'($urandom_range(8192, 1));
    wr(`RNCO_ADDR_RDIV, {16'h0, rdiv});
    for (int i = 0; i < 8; i++) rd(rnco_addr_t'(`RNCO_ADDR_FREQ0 + i), freq[i]);
    rd(`RNCO_ADDR_RDIV, {16'h0, rdiv});
    rd(12'h300, 32'h0);
    // strobe while disabled is ignored
    @(posedge clock_i);
    ce_i <= 1'b0;
    wr(`RNCO_ADDR_RDIV, {16'h0, ~rdiv});
    ce_i <= 1'b1;
    rd(`RNCO_ADDR_RDIV, {16'h0, rdiv});
    // preset from pins, then from the select register
    for (int m = 0; m < 2; m++) begin
      wr(`RNCO_ADDR_SRC, 32'(m));
      for (int p = 0; p < 8; p++) begin
        if (m == 0) preset_pins_i <= rnco_preset_t'(p);
        else wr(`RNCO_ADDR_SEL, 32'(p));
        if (m == 1) preset_pins_i <= rnco_preset_t'($urandom);
        wait_n(3);
        check("active_preset", active_preset_o, 32'(p));
        check("active_word", active_word_o, freq[p]);
        check("rdiv_o", rdiv_o, 32'(rdiv));
      end
    end
    rd(`RNCO_ADDR_ACTIVE, 32'h7);
    // plain mode wraps at 2^32
    wr(`RNCO_ADDR_RDIV, 32'h0);
    freq[7] = $urandom | 32'h80000000;
    wr(`RNCO_ADDR_FREQ7, freq[7]);
    wait_n(3);
    acc = 64'(phase_o);
    n = $urandom_range(40, 1);
    steps(n);
    wait_n(2);
    rd(`RNCO_ADDR_PHASE, 32'(acc + n * freq[7]));
    // rational mode wraps at divisor scaled by 2^25
    rdiv = 16'($urandom_range(8, 1));
    modulus = 64'(rdiv) << `RNCO_RDIV_SHIFT;
    wr(`RNCO_ADDR_RDIV, {16'h0, rdiv});
    freq[7] = 32'($urandom % modulus);
    wr(`RNCO_ADDR_FREQ7, freq[7]);
    steps(1);
    wait_n(3);
    acc = 64'(phase_o);
    steps(n);
    wait_n(2);
    rd(`RNCO_ADDR_PHASE, 32'((acc + n * freq[7]) % modulus));
    check("nondet", phase_nondet_o, 32'h0);
    // rewrite while link runs, then reinit clears
    @(posedge clock_i);
    link_running_i <= 1'b1;
    wr(`RNCO_ADDR_FREQ0, freq[0]);
    wait_n(1);
    check("nondet", phase_nondet_o, 32'h1);
    rd(`RNCO_ADDR_ACTIVE, 32'hf);
    link_running_i <= 1'b0;
    link_reinit_i  <= 1'b1;
    @(posedge clock_i);
    link_reinit_i  <= 1'b0;
    wait_n(1);
    check("nondet", phase_nondet_o, 32'h0);
    wait_n(2);
    check("read_queue", 32'(exp_q.size()), 32'h0);
    stop_test();
  end
endmodule : rnco_top_bench
`default_nettype wire
